// ---- design/sabd_decoder.sv ----
// Top of the shift, subtract and branch decoder with its APB register slave
`timescale 1ns/100ps
module sabd_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic branch_taken,
  output logic instr_ready,
  output logic dec_valid,
  output sabd_pkg::sabd_dec_type dec_info,
  output logic fetch_redirect,
  output logic other_group,
  output logic busy
);
  typedef enum logic {
    S_IDLE,
    S_EXEC
  } sabd_state_type;

  sabd_state_type state_r;
  sabd_state_type state_nxt;

  // Pattern hits, one comparator per table entry
  logic [sabd_pkg::SABD_NUM_OPS-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < sabd_pkg::SABD_NUM_OPS; gi++) begin : g_match
      sabd_opcode_match #(
        .MASK(sabd_pkg::SABD_TABLE[gi].mask),
        .VALUE(sabd_pkg::SABD_TABLE[gi].value)
      ) u_match (
        .word(instr_word),
        .hit(hit[gi])
      );
    end
  endgenerate

  // First hit in table order wins: an entry counts only if no earlier entry hits
  logic [sabd_pkg::SABD_NUM_OPS-1:0] hit_earlier;
  logic [sabd_pkg::SABD_NUM_OPS-1:0] first_hit;
  sabd_pkg::sabd_entry_type pick [sabd_pkg::SABD_NUM_OPS];
  sabd_pkg::sabd_entry_type pick_or [sabd_pkg::SABD_NUM_OPS];
  sabd_pkg::sabd_entry_type sel_entry;
  logic sel_found;

  assign hit_earlier[0] = 1'b0;
  assign first_hit = hit & ~hit_earlier;
  assign sel_found = |hit;

  // At most one pick is nonzero, so an OR merges them without a wide mux
  generate
    for (gi = 0; gi < sabd_pkg::SABD_NUM_OPS; gi++) begin : g_pick
      assign pick[gi] = first_hit[gi] ? sabd_pkg::SABD_TABLE[gi] : '0;
      if (gi == 0) begin : g_head
        assign pick_or[gi] = pick[gi];
      end else begin : g_chain
        assign hit_earlier[gi] = hit_earlier[gi-1] || hit[gi-1];
        assign pick_or[gi] = sabd_pkg::sabd_entry_type'(pick_or[gi-1] | pick[gi]);
      end
    end
  endgenerate

  assign sel_entry = pick_or[sabd_pkg::SABD_NUM_OPS-1];

  // Control register fields
  logic ctrl_en_r;
  logic ctrl_en_nxt;

  // Handshake with the fetch unit
  logic timer_busy;
  logic timer_last;
  logic accept;
  logic accept_ours;
  logic accept_other;

  assign instr_ready = ctrl_en_r && !timer_busy;
  assign accept = instr_valid && instr_ready;
  assign accept_ours = accept && sel_found;
  // Unmatched words are handed on and never timed here; they raise other_group and the other count
  assign accept_other = accept && !sel_found;

  // Outcome of a two-way instruction: first count when taken, second otherwise
  logic [3:0] sel_cycles;
  logic sel_redirect;

  assign sel_cycles = (sel_entry.two_way && !branch_taken) ?
                      sel_entry.cyc_fall : sel_entry.cyc_taken;
  // Taken branches and the counter swap move the program counter
  assign sel_redirect = sel_entry.alters_pc &&
                        (!sel_entry.two_way || branch_taken);

  // Timer covers the cycles after the first
  logic timer_load;
  logic [3:0] timer_val;

  assign timer_load = accept_ours;
  assign timer_val = 4'(sel_cycles - sabd_pkg::SABD_ONE_CYCLE);

  sabd_cycle_timer #(
    .W(4)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(timer_load),
    .load_val(timer_val),
    .busy(timer_busy),
    .last(timer_last)
  );

  // State follows the timer; single cycle work never leaves idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (accept_ours && (sel_cycles != sabd_pkg::SABD_ONE_CYCLE)) begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (timer_last) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  assign busy = (state_r == S_EXEC);

  // Decoded result, registered
  sabd_pkg::sabd_dec_type dec_r;
  sabd_pkg::sabd_dec_type dec_nxt;
  logic dec_valid_r;
  logic redirect_r;
  logic other_r;

  always_comb begin
    dec_nxt = dec_r;
    if (accept_ours) begin
      dec_nxt.op = sel_entry.op;
      dec_nxt.words = sel_entry.words;
      dec_nxt.cycles = sel_cycles;
      dec_nxt.flags = sel_entry.flags;
      // Status copy replaces the flags instead of computing them
      dec_nxt.flag_load = (sel_entry.op == sabd_pkg::OP_LOAD_STATUS_WORD);
      dec_nxt.opcode = instr_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      dec_r <= '0;
      dec_valid_r <= 1'b0;
      redirect_r <= 1'b0;
      other_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dec_r <= dec_nxt;
      dec_valid_r <= accept_ours;
      redirect_r <= accept_ours && sel_redirect;
      other_r <= accept_other;
    end
  end

  assign dec_valid = dec_valid_r;
  assign dec_info = dec_r;
  assign fetch_redirect = redirect_r;
  assign other_group = other_r;

  // APB decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_status;
  logic hit_decoded;
  logic hit_redirect;
  logic hit_other;
  logic hit_last;
  logic addr_ok;

  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign hit_ctrl = (paddr == sabd_pkg::SABD_CTRL_ADDR);
  assign hit_status = (paddr == sabd_pkg::SABD_STATUS_ADDR);
  assign hit_decoded = (paddr == sabd_pkg::SABD_DECODED_ADDR);
  assign hit_redirect = (paddr == sabd_pkg::SABD_REDIRECT_ADDR);
  assign hit_other = (paddr == sabd_pkg::SABD_OTHER_ADDR);
  assign hit_last = (paddr == sabd_pkg::SABD_LAST_ADDR);
  assign addr_ok = hit_ctrl || hit_status || hit_decoded || hit_redirect ||
                   hit_other || hit_last;

  // No wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;

  logic ctrl_wr;
  logic clr_req;

  assign ctrl_wr = apb_wr && hit_ctrl;
  assign clr_req = ctrl_wr && pwdata[sabd_pkg::SABD_CTRL_CLR_BIT];
  assign ctrl_en_nxt = ctrl_wr ? pwdata[sabd_pkg::SABD_CTRL_EN_BIT] : ctrl_en_r;

  // Event counters; an event in the clear cycle still counts
  logic [31:0] decoded_cnt_r;
  logic [31:0] decoded_cnt_nxt;
  logic [31:0] redirect_cnt_r;
  logic [31:0] redirect_cnt_nxt;
  logic [31:0] other_cnt_r;
  logic [31:0] other_cnt_nxt;
  logic [31:0] decoded_base;
  logic [31:0] redirect_base;
  logic [31:0] other_base;

  assign decoded_base = clr_req ? '0 : decoded_cnt_r;
  assign redirect_base = clr_req ? '0 : redirect_cnt_r;
  assign other_base = clr_req ? '0 : other_cnt_r;
  assign decoded_cnt_nxt = accept_ours ?
                           32'(decoded_base + sabd_pkg::SABD_COUNT_STEP) : decoded_base;
  assign redirect_cnt_nxt = (accept_ours && sel_redirect) ?
                            32'(redirect_base + sabd_pkg::SABD_COUNT_STEP) : redirect_base;
  assign other_cnt_nxt = accept_other ?
                         32'(other_base + sabd_pkg::SABD_COUNT_STEP) : other_base;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= sabd_pkg::SABD_CTRL_EN_RESET;
      decoded_cnt_r <= '0;
      redirect_cnt_r <= '0;
      other_cnt_r <= '0;
    end else begin
      ctrl_en_r <= ctrl_en_nxt;
      decoded_cnt_r <= decoded_cnt_nxt;
      redirect_cnt_r <= redirect_cnt_nxt;
      other_cnt_r <= other_cnt_nxt;
    end
  end

  // Read views
  logic [31:0] ctrl_view;
  logic [31:0] status_view;
  logic [31:0] last_view;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[sabd_pkg::SABD_CTRL_EN_BIT] = ctrl_en_r;
  end

  always_comb begin
    status_view = '0;
    status_view[sabd_pkg::SABD_ST_BUSY_BIT] = busy;
    status_view[sabd_pkg::SABD_ST_REDIR_BIT] = redirect_r;
    status_view[sabd_pkg::SABD_ST_OP_LSB +: 5] = dec_r.op;
    status_view[sabd_pkg::SABD_ST_CYC_LSB +: 4] = dec_r.cycles;
    status_view[sabd_pkg::SABD_ST_WORDS_LSB +: 2] = dec_r.words;
    status_view[sabd_pkg::SABD_ST_FLAGS_LSB +: 4] = dec_r.flags;
  end

  assign last_view = {16'h0000, dec_r.opcode};

  assign rd_mux = hit_ctrl ? ctrl_view :
                  hit_status ? status_view :
                  hit_decoded ? decoded_cnt_r :
                  hit_redirect ? redirect_cnt_r :
                  hit_other ? other_cnt_r :
                  hit_last ? last_view : '0;

  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  assign prdata_nxt = (apb_setup && !pwrite) ? rd_mux : prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
endmodule

// ---- design/sabd_pkg.sv ----
// Package of the shift, subtract and branch decoder: opcode table, register map, carriers
// Behaviour
// - arith_left_shift constant, prefix 0010 00, 3 cycles, NCZV
// - logic_left_shift constant, prefix 0010 01, 1 cycle, CZ
// - arith_right_shift by register, prefix 0110 010, NCZ
// - logic_right_shift constant, prefix 0010 11, CZ
// - subtract_immediate 16-bit, two words, 2 cycles, NCZV
// - subtract_immediate 32-bit, three words, 3 cycles, NCZV
// - subtract_small_constant, prefix 0001 01, 1 cycle, NCZV
// - exclusive_or_immediate, three words, 3 cycles, Z only
// - two counts: first taken, second falls through
// - decrement_skip_jump, two words, 3 taken, 2 not
// - short_decrement_skip_jump, prefix 0011 1, 2 or 3
// - short relative_conditional_jump, one word, 2 or 1
// - swap_program_counter, one word, 2 cycles, no flags
// - read_program_counter, low bits 010, 1 cycle
// - read_status_word, low bits 100, 1 cycle
// - pull status 8 cycles, save 2, one word
// - save_status_word, low byte 1110 0000, 2 cycles
// - load_status_word, low bits 101, overwrites NCZV
// - absolute_conditional_jump, three words, 3 taken, 4 not
package sabd_pkg;
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ARITH_LEFT_SHIFT,
    OP_LOGIC_LEFT_SHIFT,
    OP_ARITH_RIGHT_SHIFT,
    OP_LOGIC_RIGHT_SHIFT,
    OP_SUBTRACT_IMMEDIATE_16,
    OP_SUBTRACT_IMMEDIATE_32,
    OP_SUBTRACT_SMALL_CONSTANT,
    OP_EXCLUSIVE_OR_IMMEDIATE,
    OP_DECREMENT_SKIP_JUMP,
    OP_SHORT_DECREMENT_SKIP_JUMP,
    OP_RELATIVE_CONDITIONAL_JUMP,
    OP_LONG_RELATIVE_CONDITIONAL_JUMP,
    OP_ABSOLUTE_CONDITIONAL_JUMP,
    OP_SWAP_PROGRAM_COUNTER,
    OP_READ_PROGRAM_COUNTER,
    OP_READ_STATUS_WORD,
    OP_PULL_STATUS_WORD,
    OP_SAVE_STATUS_WORD,
    OP_LOAD_STATUS_WORD
  } sabd_op_type;

  // Flag masks, bit order N C Z V
  localparam logic [3:0] FL_NONE = 4'h0;
  localparam logic [3:0] FL_NCZV = 4'hF;
  localparam logic [3:0] FL_NCZ = 4'hE;
  localparam logic [3:0] FL_CZ = 4'h6;
  localparam logic [3:0] FL_Z = 4'h2;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] value;
    sabd_op_type op;
    logic [1:0] words;
    logic [3:0] cyc_taken;
    logic [3:0] cyc_fall;
    logic [3:0] flags;
    logic two_way;
    logic alters_pc;
  } sabd_entry_type;

  // Decoded result handed to the core
  typedef struct packed {
    sabd_op_type op;
    logic [1:0] words;
    logic [3:0] cycles;
    logic [3:0] flags;
    logic flag_load;
    logic [15:0] opcode;
  } sabd_dec_type;

  localparam int SABD_NUM_OPS = 19;
  // First hit wins, so the fixed low-byte jump forms come before the short one
  localparam sabd_entry_type SABD_TABLE [SABD_NUM_OPS] = '{
    '{16'hF0FF, 16'hC080, OP_ABSOLUTE_CONDITIONAL_JUMP, 2'h3, 4'h3, 4'h4, FL_NONE, 1'b1, 1'b1},
    '{16'hF0FF, 16'hC000, OP_LONG_RELATIVE_CONDITIONAL_JUMP, 2'h2, 4'h3, 4'h2, FL_NONE, 1'b1, 1'b1},
    '{16'hF000, 16'hC000, OP_RELATIVE_CONDITIONAL_JUMP, 2'h1, 4'h2, 4'h1, FL_NONE, 1'b1, 1'b1},
    '{16'hFC00, 16'h2000, OP_ARITH_LEFT_SHIFT, 2'h1, 4'h3, 4'h3, FL_NCZV, 1'b0, 1'b0},
    '{16'hFC00, 16'h2400, OP_LOGIC_LEFT_SHIFT, 2'h1, 4'h1, 4'h1, FL_CZ, 1'b0, 1'b0},
    '{16'hFE00, 16'h6400, OP_ARITH_RIGHT_SHIFT, 2'h1, 4'h1, 4'h1, FL_NCZ, 1'b0, 1'b0},
    '{16'hFC00, 16'h2C00, OP_LOGIC_RIGHT_SHIFT, 2'h1, 4'h1, 4'h1, FL_CZ, 1'b0, 1'b0},
    '{16'hFFE0, 16'h0BE0, OP_SUBTRACT_IMMEDIATE_16, 2'h2, 4'h2, 4'h2, FL_NCZV, 1'b0, 1'b0},
    '{16'hFFE0, 16'h0D00, OP_SUBTRACT_IMMEDIATE_32, 2'h3, 4'h3, 4'h3, FL_NCZV, 1'b0, 1'b0},
    '{16'hFC00, 16'h1400, OP_SUBTRACT_SMALL_CONSTANT, 2'h1, 4'h1, 4'h1, FL_NCZV, 1'b0, 1'b0},
    '{16'hFFE0, 16'h0BC0, OP_EXCLUSIVE_OR_IMMEDIATE, 2'h3, 4'h3, 4'h3, FL_Z, 1'b0, 1'b0},
    '{16'hFFE0, 16'h0D80, OP_DECREMENT_SKIP_JUMP, 2'h2, 4'h3, 4'h2, FL_NONE, 1'b1, 1'b1},
    '{16'hF800, 16'h3800, OP_SHORT_DECREMENT_SKIP_JUMP, 2'h1, 4'h2, 4'h3, FL_NONE, 1'b1, 1'b1},
    '{16'hFFE0, 16'h0120, OP_SWAP_PROGRAM_COUNTER, 2'h1, 4'h2, 4'h2, FL_NONE, 1'b0, 1'b1},
    '{16'hFFE0, 16'h0140, OP_READ_PROGRAM_COUNTER, 2'h1, 4'h1, 4'h1, FL_NONE, 1'b0, 1'b0},
    '{16'hFFE0, 16'h0180, OP_READ_STATUS_WORD, 2'h1, 4'h1, 4'h1, FL_NONE, 1'b0, 1'b0},
    '{16'hFFFF, 16'h01C0, OP_PULL_STATUS_WORD, 2'h1, 4'h8, 4'h8, FL_NONE, 1'b0, 1'b0},
    '{16'hFFFF, 16'h01E0, OP_SAVE_STATUS_WORD, 2'h1, 4'h2, 4'h2, FL_NONE, 1'b0, 1'b0},
    '{16'hFFE0, 16'h01A0, OP_LOAD_STATUS_WORD, 2'h1, 4'h3, 4'h3, FL_NCZV, 1'b0, 1'b0}
  };

  localparam logic [3:0] SABD_ONE_CYCLE = 4'h1;
  localparam logic [31:0] SABD_COUNT_STEP = 32'h1;

  // Register map, byte addresses
  localparam int SABD_ADDR_W = 12;
  localparam logic [11:0] SABD_CTRL_ADDR = 12'h000;
  localparam logic [11:0] SABD_STATUS_ADDR = 12'h004;
  localparam logic [11:0] SABD_DECODED_ADDR = 12'h008;
  localparam logic [11:0] SABD_REDIRECT_ADDR = 12'h00C;
  localparam logic [11:0] SABD_OTHER_ADDR = 12'h010;
  localparam logic [11:0] SABD_LAST_ADDR = 12'h014;

  localparam int SABD_CTRL_EN_BIT = 0;
  localparam int SABD_CTRL_CLR_BIT = 1;
  localparam logic SABD_CTRL_EN_RESET = 1'b1;
  localparam int SABD_ST_BUSY_BIT = 0;
  localparam int SABD_ST_REDIR_BIT = 1;
  localparam int SABD_ST_OP_LSB = 8;
  localparam int SABD_ST_CYC_LSB = 16;
  localparam int SABD_ST_WORDS_LSB = 20;
  localparam int SABD_ST_FLAGS_LSB = 24;
endpackage

// ---- design/sabd_opcode_match.sv ----
// One opcode pattern comparator: mask and value
`timescale 1ns/100ps
module sabd_opcode_match #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] VALUE = 16'h0000
) (
  input wire logic [15:0] word,
  output logic hit
);
  assign hit = ((word & MASK) == VALUE);
endmodule

// ---- design/sabd_cycle_timer.sv ----
// Down counter holding the decoder for the remaining cycles of an instruction
`timescale 1ns/100ps
module sabd_cycle_timer #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy,
  output logic last
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] STEP = {{(W-1){1'b0}}, 1'b1};

  assign busy = (count_r != ZERO);
  assign last = (count_r == STEP);
  assign count_nxt = load ? load_val : (busy ? W'(count_r - STEP) : ZERO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

// ---- verification/sabd_decoder_assertions.sv ----
// Concurrent checks on the fetch side of the decoder
`timescale 1ns/100ps
module sabd_decoder_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic branch_taken,
  input wire logic instr_ready,
  input wire logic dec_valid,
  input wire sabd_pkg::sabd_dec_type dec_info,
  input wire logic fetch_redirect,
  input wire logic other_group
);
  logic tk;
  assign tk = instr_valid && instr_ready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tk(logic [15:0] m, logic [15:0] v);
    tk && ((instr_word & m) == v);
  endsequence
  sequence s_wait2;
    !instr_ready ##1 instr_ready;
  endsequence
  // Long stack access keeps the fetch side blocked
  sequence s_wait8;
    !instr_ready [*7] ##1 instr_ready;
  endsequence
  // Fixed low bytes belong to the long jump forms
  sequence s_jr;
    s_tk(16'hF000, 16'hC000) ##0 (instr_word[7:0] != 8'h00 && instr_word[7:0] != 8'h80);
  endsequence
  chk_als_cycles: assert property (s_tk(16'hFC00, 16'h2000) |=>
    (dec_valid && dec_info.cycles == 4'h3 && dec_info.flags == 4'hF) ##0 !instr_ready ##1 s_wait2)
    else $error("arith left shift decode wrong");
  chk_lls_flags: assert property (s_tk(16'hFC00, 16'h2400) |=>
    dec_info.cycles == 4'h1 && dec_info.flags == 4'h6) else $error("logic left shift wrong");
  chk_ars_flags: assert property (s_tk(16'hFE00, 16'h6400) |=>
    dec_info.cycles == 4'h1 && dec_info.flags == 4'hE) else $error("arith right shift wrong");
  chk_sub_short: assert property (s_tk(16'hFFE0, 16'h0BE0) |=>
    dec_info.words == 2'h2 && dec_info.cycles == 4'h2 && dec_info.flags == 4'hF)
    else $error("short subtract wrong");
  chk_xor_zero: assert property (s_tk(16'hFFE0, 16'h0BC0) |=>
    dec_info.words == 2'h3 && dec_info.cycles == 4'h3 && dec_info.flags == 4'h2)
    else $error("exclusive or wrong");
  chk_jr_count: assert property (s_jr |=>
    dec_info.cycles == ($past(branch_taken) ? 4'h2 : 4'h1) && fetch_redirect == $past(branch_taken))
    else $error("short jump wrong");
  chk_ja_count: assert property (s_tk(16'hF0FF, 16'hC080) |=>
    dec_info.words == 2'h3 && dec_info.cycles == ($past(branch_taken) ? 4'h3 : 4'h4))
    else $error("absolute jump wrong");
  chk_swap_redir: assert property (s_tk(16'hFFE0, 16'h0120) |=>
    fetch_redirect && dec_info.cycles == 4'h2 && dec_info.flags == 4'h0) else $error("swap wrong");
  chk_pull_hold: assert property (s_tk(16'hFFFF, 16'h01C0) |=> s_wait8)
    else $error("pull status timing wrong");
  chk_save_hold: assert property (s_tk(16'hFFFF, 16'h01E0) |=> s_wait2)
    else $error("save status timing wrong");
  chk_load_flags: assert property (s_tk(16'hFFE0, 16'h01A0) |=>
    dec_info.flag_load && dec_info.flags == 4'hF) else $error("load status wrong");
  chk_other_grp: assert property (s_tk(16'hFFFF, 16'h0000) |=>
    other_group && !dec_valid) else $error("unlisted word decoded");
endmodule
bind sabd_decoder sabd_decoder_assertions sabd_decoder_assertions_i (.pclk(pclk),
  .presetn(presetn), .instr_valid(instr_valid), .instr_word(instr_word),
  .branch_taken(branch_taken), .instr_ready(instr_ready), .dec_valid(dec_valid),
  .dec_info(dec_info), .fetch_redirect(fetch_redirect), .other_group(other_group));

// ---- verification/test_sabd_decoder.sv ----
// Self-checking bench for the shift, subtract and branch decoder
`timescale 1ns/100ps
module test_sabd_decoder;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, perr;
  logic instr_valid = 1'h0;
  logic branch_taken = 1'h0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready, dec_valid, fetch_redirect, other_group, busy;
  sabd_pkg::sabd_dec_type dec_info;
  int n_fail = 0;
  int total_checks = 0;
  int nd = 0;
  int nr = 0;
  int no = 0;
  always #12.5 pclk = ~pclk;
  sabd_decoder sabd_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .branch_taken(branch_taken), .instr_ready(instr_ready), .dec_valid(dec_valid),
    .dec_info(dec_info), .fetch_redirect(fetch_redirect), .other_group(other_group), .busy(busy));
  task wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task to_chk(input int n);
    if (n >= 20) begin
      n_fail++;
      wrap_up;
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    to_chk(n);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'h0, a, 32'h0);
    cmp(q, e);
    cmp({31'h0, perr}, {31'h0, err});
  endtask
  // Op code zero means a word of another group
  task ins(input logic [15:0] w, input logic bt, input logic [4:0] op, input logic [1:0] wd,
           input logic [3:0] cy, input logic [3:0] fl, input logic rdr);
    int n;
    n = 0;
    @(posedge pclk);
    instr_valid <= 1'h1;
    instr_word <= w;
    branch_taken <= bt;
    do begin
      @(negedge pclk);
      n++;
    end while (instr_ready !== 1'h1 && n < 20);
    to_chk(n);
    @(posedge pclk);
    instr_valid <= 1'h0;
    @(negedge pclk);
    cmp({dec_valid, other_group, fetch_redirect, busy},
        {op != 5'h00, op == 5'h00, rdr, cy != 4'h1});
    if (op != 5'h00)
      cmp(dec_info, {op, wd, cy, fl, op == 5'h13, w});
    nd += (op != 5'h00);
    nr += rdr;
    no += (op == 5'h00);
    n = 1;
    while (instr_ready !== 1'h1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    cmp(n, cy);
    to_chk(n);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h000, 32'h1, 1'h0);
    rd(12'h020, 32'h0, 1'h1);
    ins(16'h2000, 1'h0, 5'h01, 2'h1, 4'h3, 4'hF, 1'h0);
    ins(16'h27FF, 1'h0, 5'h02, 2'h1, 4'h1, 4'h6, 1'h0);
    ins(16'h65FF, 1'h0, 5'h03, 2'h1, 4'h1, 4'hE, 1'h0);
    ins(16'h2C00, 1'h0, 5'h04, 2'h1, 4'h1, 4'h6, 1'h0);
    ins(16'h0BEF, 1'h0, 5'h05, 2'h2, 4'h2, 4'hF, 1'h0);
    ins(16'h0D1F, 1'h0, 5'h06, 2'h3, 4'h3, 4'hF, 1'h0);
    ins(16'h17FF, 1'h0, 5'h07, 2'h1, 4'h1, 4'hF, 1'h0);
    ins(16'h0BC3, 1'h0, 5'h08, 2'h3, 4'h3, 4'h2, 1'h0);
    ins(16'h0D85, 1'h1, 5'h09, 2'h2, 4'h3, 4'h0, 1'h1);
    ins(16'h0D85, 1'h0, 5'h09, 2'h2, 4'h2, 4'h0, 1'h0);
    ins(16'h3C21, 1'h1, 5'h0A, 2'h1, 4'h2, 4'h0, 1'h1);
    ins(16'h3C21, 1'h0, 5'h0A, 2'h1, 4'h3, 4'h0, 1'h0);
    ins(16'hC5FF, 1'h1, 5'h0B, 2'h1, 4'h2, 4'h0, 1'h1);
    ins(16'hC501, 1'h0, 5'h0B, 2'h1, 4'h1, 4'h0, 1'h0);
    ins(16'hC380, 1'h1, 5'h0D, 2'h3, 4'h3, 4'h0, 1'h1);
    ins(16'hC380, 1'h0, 5'h0D, 2'h3, 4'h4, 4'h0, 1'h0);
    ins(16'hC400, 1'h1, 5'h0C, 2'h2, 4'h3, 4'h0, 1'h1);
    ins(16'hC400, 1'h0, 5'h0C, 2'h2, 4'h2, 4'h0, 1'h0);
    ins(16'h0000, 1'h0, 5'h00, 2'h1, 4'h1, 4'h0, 1'h0);
    ins(16'h4000, 1'h0, 5'h00, 2'h1, 4'h1, 4'h0, 1'h0);
    ins(16'h0127, 1'h0, 5'h0E, 2'h1, 4'h2, 4'h0, 1'h1);
    ins(16'h0140, 1'h0, 5'h0F, 2'h1, 4'h1, 4'h0, 1'h0);
    ins(16'h0189, 1'h0, 5'h10, 2'h1, 4'h1, 4'h0, 1'h0);
    ins(16'h01C0, 1'h0, 5'h11, 2'h1, 4'h8, 4'h0, 1'h0);
    ins(16'h01E0, 1'h0, 5'h12, 2'h1, 4'h2, 4'h0, 1'h0);
    ins(16'h01A3, 1'h0, 5'h13, 2'h1, 4'h3, 4'hF, 1'h0);
    rd(12'h004, 32'h0F131300, 1'h0);
    rd(12'h008, nd, 1'h0);
    rd(12'h00C, nr, 1'h0);
    rd(12'h010, no, 1'h0);
    rd(12'h014, 32'h01A3, 1'h0);
    apb(1'h1, 12'h000, 32'h3);
    rd(12'h008, 32'h0, 1'h0);
    // Enable off must refuse new words
    apb(1'h1, 12'h000, 32'h0);
    @(negedge pclk);
    cmp({31'h0, instr_ready}, 32'h0);
    apb(1'h1, 12'h000, 32'h1);
    ins(16'h2400, 1'h0, 5'h02, 2'h1, 4'h1, 4'h6, 1'h0);
    // Reset in mid-run turns enable back on and clears the decode result
    apb(1'h1, 12'h000, 32'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h000, 32'h1, 1'h0);
    rd(12'h004, 32'h0, 1'h0);
    wrap_up;
  end
endmodule
